/* include/crs_pkg.sv */
// constants of the reset, strap and clock-setup block
package crs_pkg;

    localparam int CRS_AW = 12;

    // register byte offsets
    localparam logic [11:0] CRS_CTRL_OFF = 12'h000;
    localparam logic [11:0] CRS_STAT_OFF = 12'h004;
    localparam logic [11:0] CRS_EVT_OFF = 12'h008;
    localparam logic [11:0] CRS_RATIO_OFF = 12'h00C;

    // control fields
    localparam int CRS_CTRL_CHK = 0;
    localparam logic [31:0] CRS_CTRL_RST = 32'h0000_0001;

    // status fields
    localparam int CRS_ST_BIG = 0;
    localparam int CRS_ST_RATIO = 1;
    localparam int CRS_ST_BYP_N = 3;
    localparam int CRS_ST_CMP_N = 4;
    localparam int CRS_ST_VALID = 5;
    localparam int CRS_ST_FSM = 6;
    localparam int CRS_ST_COLD = 10;

    // event fields, write one to clear
    localparam int CRS_EV_COLD = 0;
    localparam int CRS_EV_WARM = 1;
    localparam int CRS_EV_SHORT_COLD = 2;
    localparam int CRS_EV_SHORT_WARM = 3;
    localparam int CRS_EV_W = 4;

    // ratio register fields
    localparam int CRS_RT_HALF = 4;

    // minimum hold counts, in bus clock cycles
    localparam int CRS_COLD_MIN = 65536;
    localparam int CRS_RESTART_MIN = 64;
    localparam int CRS_CNT_W = 18;

    // strap reset values until first capture
    localparam logic [1:0] CRS_RATIO_RST = 2'h0;

    typedef enum logic [3:0] {
        CRS_COLD = 4'b0001,
        CRS_HOLD = 4'b0010,
        CRS_WARM = 4'b0100,
        CRS_RUN = 4'b1000
    } crs_state_e;

endpackage

/* rtl/crs_pin_sync.sv */
// three-stage pin synchroniser with agreement filter
module crs_pin_sync
    import crs_pkg::*;
#(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // s1 feeds only s2; output follows once s2 and s3 agree
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1 <= RST;
            s2 <= RST;
            s3 <= RST;
            q <= RST;
        end
        else
        begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            for (int i = 0; i < W; i++)
            begin
                if (s2[i] == s3[i])
                begin
                    q[i] <= s3[i];
                end
            end
        end
    end

endmodule

/* rtl/crs_byp_phase.sv */
// half-rate system clock phase for clock bypass mode
module crs_byp_phase
    import crs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic align,
    output logic phase,
    output logic rise
);

    logic next_phase;

    // align edge is a falling edge, so the next one rises
    assign next_phase = align ? 1'b0 : ~phase;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase <= 1'b0;
            rise <= 1'b0;
        end
        else
        begin
            phase <= next_phase;
            rise <= next_phase;
        end
    end

endmodule

/* rtl/crs_reset_init.sv */
// reset sequencer, strap latch, clock setup and apb status block
module crs_reset_init
    import crs_pkg::*;
#(
    parameter int COLD_MIN = CRS_COLD_MIN,
    parameter int RESTART_MIN = CRS_RESTART_MIN
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [CRS_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic full_init_n,
    input wire logic logic_restart_n,
    input wire logic byte_order_sel,
    input wire logic [1:0] core_ratio_sel,
    input wire logic pll_skip_n,
    input wire logic compat_protocol_sel_n,
    output logic core_rst_n,
    output logic jtag_rst_n,
    output logic clk_restart,
    output logic fsm_rst,
    output logic bpt_clear,
    output logic abort_multicycle,
    output logic load_wb_kill,
    output logic reset_vec_go,
    output logic reset_vec_cold,
    output logic [31:0] sys_addr_data_bus_o,
    output logic sys_addr_data_bus_oe,
    output logic big_endian,
    output logic [1:0] ratio_sel,
    output logic [3:0] core_mult_x2,
    output logic core_half_phase,
    output logic pll_bypass,
    output logic compat_proto,
    output logic sys_clk_phase,
    output logic sys_clk_rise
);

    ////////////////////////////////////////////////////////////////////////////
    // ratio table: core clock over bus clock, times two

    function automatic logic [3:0] ratio_x2(input logic [1:0] code);
        logic [3:0] r;
        r = 4'h4;
        unique case (code)
            2'h0: r = 4'h8;
            2'h1: r = 4'h6;
            2'h2: r = 4'h5;
            2'h3: r = 4'h4;
        endcase
        return r;
    endfunction

    function automatic logic [CRS_CNT_W-1:0] sat_inc(input logic [CRS_CNT_W-1:0] v);
        return (&v) ? v : v + 1'b1;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic init_f;
    logic restart_f;
    logic [4:0] strap_f;

    crs_pin_sync #(.W(2), .RST(2'b00)) u_rst_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d({full_init_n, logic_restart_n}),
        .q({init_f, restart_f})
    );

    crs_pin_sync #(.W(5), .RST(5'b0_1100)) u_strap_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d({byte_order_sel, core_ratio_sel, pll_skip_n, compat_protocol_sel_n}),
        .q(strap_f)
    );

    ////////////////////////////////////////////////////////////////////////////
    // sequencer

    crs_state_e state;
    crs_state_e next_state;
    logic init_q;
    logic cap_pend;
    logic from_cold;
    logic [CRS_CNT_W-1:0] hold_cnt;
    logic [CRS_CNT_W-1:0] next_hold_cnt;

    wire init_rel = init_f & ~init_q;
    wire in_reset = (state != CRS_RUN);
    wire leave_reset = in_reset & (next_state == CRS_RUN);
    wire cold_enter = ~init_f & (state != CRS_COLD);
    wire warm_enter = (state == CRS_RUN) & init_f & ~restart_f;

    always_comb
    begin
        next_state = state;
        unique case (state)
            CRS_COLD:
            begin
                if (init_f)
                begin
                    next_state = restart_f ? CRS_RUN : CRS_HOLD;
                end
            end
            CRS_HOLD, CRS_WARM:
            begin
                if (!init_f)
                begin
                    next_state = CRS_COLD;
                end
                else if (restart_f)
                begin
                    next_state = CRS_RUN;
                end
            end
            CRS_RUN:
            begin
                if (!init_f)
                begin
                    next_state = CRS_COLD;
                end
                else if (!restart_f)
                begin
                    next_state = CRS_WARM;
                end
            end
            default: next_state = CRS_COLD;
        endcase
    end

    // cycles the current reset input has been low, restarted at each phase
    assign next_hold_cnt = (cold_enter | warm_enter | init_rel) ? '0 :
        in_reset ? sat_inc(hold_cnt) : hold_cnt;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= CRS_COLD;
            init_q <= 1'b0;
            cap_pend <= 1'b0;
            from_cold <= 1'b1;
            hold_cnt <= '0;
        end
        else
        begin
            state <= next_state;
            init_q <= init_f;
            cap_pend <= init_rel;
            hold_cnt <= next_hold_cnt;
            if (cold_enter)
            begin
                from_cold <= 1'b1;
            end
            else if (warm_enter)
            begin
                from_cold <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reset outputs

    // assertion straight from the pins so in-flight work stops at once (abort_multicycle and load_wb_kill from logic_restart_n only);
    // release waits for the synchronised sequencer
    assign core_rst_n = logic_restart_n & full_init_n & ~in_reset;
    assign fsm_rst = ~core_rst_n;
    assign abort_multicycle = ~logic_restart_n | in_reset;
    assign load_wb_kill = ~logic_restart_n | in_reset;
    assign jtag_rst_n = full_init_n & (state != CRS_COLD);
    assign sys_addr_data_bus_oe = ~core_rst_n;
    assign sys_addr_data_bus_o = 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            clk_restart <= 1'b0;
            bpt_clear <= 1'b0;
            reset_vec_go <= 1'b0;
            reset_vec_cold <= 1'b1;
        end
        else
        begin
            clk_restart <= cold_enter;
            bpt_clear <= cold_enter | warm_enter;
            reset_vec_go <= leave_reset;
            if (leave_reset)
            begin
                reset_vec_cold <= from_cold;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // strap latch, one cycle after release of full init

    logic straps_valid;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            big_endian <= 1'b0;
            ratio_sel <= CRS_RATIO_RST;
            pll_bypass <= 1'b0;
            compat_proto <= 1'b0;
            straps_valid <= 1'b0;
        end
        else if (cap_pend)
        begin
            big_endian <= strap_f[4];
            ratio_sel <= strap_f[3:2];
            pll_bypass <= ~strap_f[1];
            compat_proto <= ~strap_f[0];
            straps_valid <= 1'b1;
        end
        else if (cold_enter)
        begin
            straps_valid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // clock setup

    logic byp_phase;
    logic byp_rise;

    assign core_mult_x2 = pll_bypass ? 4'h4 : ratio_x2(ratio_sel);
    // odd doubled ratio means edges land on the opposite bus phase
    assign core_half_phase = core_mult_x2[0];

    // the incoming clock drives the phase divider; the edge that samples
    // the release is the one the alignment is taken from
    crs_byp_phase u_byp (
        .clk(pclk),
        .rst_n(presetn),
        .align(init_rel),
        .phase(byp_phase),
        .rise(byp_rise)
    );

    // with the pll in use the system clock is the bus clock itself
    assign sys_clk_phase = pll_bypass ? byp_phase : 1'b1;
    assign sys_clk_rise = pll_bypass ? byp_rise : 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // hold-time checks and events

    logic [31:0] ctrl;
    logic [CRS_EV_W-1:0] evt;
    logic [CRS_EV_W-1:0] evt_set;
    logic [CRS_EV_W-1:0] evt_clr;

    wire chk_en = ctrl[CRS_CTRL_CHK];
    // the pins are the other party's, these only report a short hold
    wire short_cold = init_rel & (hold_cnt < CRS_CNT_W'(COLD_MIN));
    wire short_warm = leave_reset & (hold_cnt < CRS_CNT_W'(RESTART_MIN));

    assign evt_set[CRS_EV_COLD] = leave_reset & from_cold;
    assign evt_set[CRS_EV_WARM] = leave_reset & ~from_cold;
    assign evt_set[CRS_EV_SHORT_COLD] = chk_en & short_cold;
    assign evt_set[CRS_EV_SHORT_WARM] = chk_en & short_warm;

    ////////////////////////////////////////////////////////////////////////////
    // apb slave

    wire setup = psel & ~penable;
    wire wr_acc = psel & penable & pwrite;
    wire hit_ctrl = (paddr == CRS_CTRL_OFF);
    wire hit_stat = (paddr == CRS_STAT_OFF);
    wire hit_evt = (paddr == CRS_EVT_OFF);
    wire hit_ratio = (paddr == CRS_RATIO_OFF);
    wire hit_any = hit_ctrl | hit_stat | hit_evt | hit_ratio;

    logic [31:0] stat_word;
    logic [31:0] ratio_word;
    logic [31:0] rd_mux;

    assign evt_clr = (wr_acc & hit_evt) ? pwdata[CRS_EV_W-1:0] : '0;

    always_comb
    begin
        stat_word = 32'h0000_0000;
        stat_word[CRS_ST_BIG] = big_endian;
        stat_word[CRS_ST_RATIO +: 2] = ratio_sel;
        stat_word[CRS_ST_BYP_N] = ~pll_bypass;
        stat_word[CRS_ST_CMP_N] = ~compat_proto;
        stat_word[CRS_ST_VALID] = straps_valid;
        stat_word[CRS_ST_FSM +: 4] = state;
        stat_word[CRS_ST_COLD] = from_cold;
        ratio_word = 32'h0000_0000;
        ratio_word[3:0] = core_mult_x2;
        ratio_word[CRS_RT_HALF] = core_half_phase;
    end

    assign rd_mux = hit_ctrl ? ctrl :
        hit_stat ? stat_word :
        hit_evt ? {{(32 - CRS_EV_W){1'b0}}, evt} :
        hit_ratio ? ratio_word : 32'h0000_0000;

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit_any;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl <= CRS_CTRL_RST;
            evt <= '0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            if (wr_acc & hit_ctrl)
            begin
                ctrl <= {31'h0000_0000, pwdata[CRS_CTRL_CHK]};
            end
            // a set in the clearing cycle survives
            evt <= (evt & ~evt_clr) | evt_set;
            if (setup)
            begin
                prdata <= rd_mux;
            end
        end
    end

endmodule

/* verif/crs_reset_init_asserts.sv */
// concurrent checks on the reset sequencer ports
module crs_reset_init_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pslverr,
    input wire logic full_init_n,
    input wire logic logic_restart_n,
    input wire logic core_rst_n,
    input wire logic jtag_rst_n,
    input wire logic clk_restart,
    input wire logic bpt_clear,
    input wire logic abort_multicycle,
    input wire logic load_wb_kill,
    input wire logic reset_vec_go,
    input wire logic sys_addr_data_bus_oe,
    input wire logic [1:0] ratio_sel,
    input wire logic [3:0] core_mult_x2,
    input wire logic core_half_phase,
    input wire logic pll_bypass
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////
    chk_bus_driven: assert property (!core_rst_n |-> sys_addr_data_bus_oe)
        else $error("bus released during reset");
    chk_warm_abort: assert property (!logic_restart_n |->
        !core_rst_n && abort_multicycle && load_wb_kill)
        else $error("restart pin low without abort");
    // core_rst_n drops with the pin, so key on the pin edge itself
    chk_warm_keeps: assert property ($fell(logic_restart_n) && full_init_n |->
        jtag_rst_n && !clk_restart)
        else $error("warm entry disturbed clocks or test logic");
    chk_jtag_cold: assert property (!full_init_n |-> !jtag_rst_n)
        else $error("test logic not reset in cold reset");
    chk_clk_restart: assert property ($fell(full_init_n) |-> ##[1:6] clk_restart)
        else $error("clocks not restarted on cold entry");
    chk_bpt_clear: assert property ($fell(core_rst_n) |-> ##[1:6] bpt_clear)
        else $error("prediction table not cleared");
    chk_vec_start: assert property ($rose(core_rst_n) |-> ##[0:1] reset_vec_go)
        else $error("no start at reset vector");
    chk_vec_run: assert property (reset_vec_go |-> core_rst_n)
        else $error("vector taken while in reset");
    chk_ratio_map: assert property (!pll_bypass |->
        core_mult_x2 == ((ratio_sel == 2'h0) ? 4'h8 : (ratio_sel == 2'h1) ? 4'h6 :
        (ratio_sel == 2'h2) ? 4'h5 : 4'h4))
        else $error("ratio table mismatch");
    chk_bypass_ratio: assert property (pll_bypass |-> core_mult_x2 == 4'h4)
        else $error("bypass ratio not two");
    chk_half_phase: assert property (core_half_phase == core_mult_x2[0])
        else $error("half phase wrong");
    chk_err_phase: assert property (pslverr |-> psel && penable)
        else $error("error outside access phase");
    // main scenarios reached
    cover property (reset_vec_go && core_rst_n && full_init_n);
    cover property ($fell(logic_restart_n) && full_init_n);
    cover property (pslverr);
    cover property (pll_bypass && core_rst_n);
endmodule
bind crs_reset_init crs_reset_init_asserts u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pslverr(pslverr), .full_init_n(full_init_n),
    .logic_restart_n(logic_restart_n), .core_rst_n(core_rst_n), .jtag_rst_n(jtag_rst_n),
    .clk_restart(clk_restart), .bpt_clear(bpt_clear), .abort_multicycle(abort_multicycle),
    .load_wb_kill(load_wb_kill), .reset_vec_go(reset_vec_go),
    .sys_addr_data_bus_oe(sys_addr_data_bus_oe), .ratio_sel(ratio_sel),
    .core_mult_x2(core_mult_x2), .core_half_phase(core_half_phase), .pll_bypass(pll_bypass));

/* verif/crs_ctl_model.sv */
// external reset and strap controller model
module crs_ctl_model #(
    parameter int COLD_HOLD = 24,
    parameter int RESTART_HOLD = 12
)
(
    input wire logic pclk,
    output logic full_init_n,
    output logic logic_restart_n,
    output logic byte_order_sel,
    output logic [1:0] core_ratio_sel,
    output logic pll_skip_n,
    output logic compat_protocol_sel_n
);
    timeunit 1ns;
    timeprecision 1ns;
    // no bus agents here, so nothing contends on the shared bus after reset
    initial
    begin
        full_init_n = 1'b0;
        logic_restart_n = 1'b0;
        {byte_order_sel, core_ratio_sel, pll_skip_n, compat_protocol_sel_n} = 5'h02;
    end
    task set_straps(input logic [1:0] c, input logic b, input logic p, input logic m);
        @(posedge pclk);
        {byte_order_sel, core_ratio_sel, pll_skip_n, compat_protocol_sel_n} <= {b, c, p, m};
    endtask
    task cold_enter(input logic [1:0] c, input logic b, input logic p, input logic m);
        @(posedge pclk);
        full_init_n <= 1'b0;
        logic_restart_n <= 1'b0;
        {byte_order_sel, core_ratio_sel, pll_skip_n, compat_protocol_sel_n} <= {b, c, p, m};
        repeat (COLD_HOLD) @(posedge pclk);
    endtask
    task cold_leave;
        @(posedge pclk);
        full_init_n <= 1'b1;
        repeat (RESTART_HOLD) @(posedge pclk);
        logic_restart_n <= 1'b1;
    endtask
    task restart_low;
        @(posedge pclk);
        logic_restart_n <= 1'b0;
    endtask
    task restart_high;
        @(posedge pclk);
        logic_restart_n <= 1'b1;
    endtask
endmodule

/* verif/crs_reset_init_test.sv */
// self-checking bench of the reset sequencer
module crs_reset_init_test
    import crs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CMIN = 16;
    localparam int RMIN = 8;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [CRS_AW-1:0] paddr;
    logic [31:0] pwdata, prdata, bus_o, rd;
    logic full_init_n, logic_restart_n, byte_order_sel, pll_skip_n, compat_protocol_sel_n;
    logic [1:0] core_ratio_sel, ratio_sel;
    logic core_rst_n, jtag_rst_n, clk_restart, fsm_rst, bpt_clear, abort_multicycle;
    logic load_wb_kill, reset_vec_go, reset_vec_cold, bus_oe, big_endian, core_half_phase;
    logic pll_bypass, compat_proto, sys_clk_phase, sys_clk_rise;
    logic [3:0] core_mult_x2;
    int errors, compares;
    ////////////////////////////////////////////////////////////////////////
    crs_reset_init #(.COLD_MIN(CMIN), .RESTART_MIN(RMIN)) u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .full_init_n(full_init_n),
        .logic_restart_n(logic_restart_n), .byte_order_sel(byte_order_sel),
        .core_ratio_sel(core_ratio_sel), .pll_skip_n(pll_skip_n),
        .compat_protocol_sel_n(compat_protocol_sel_n), .core_rst_n(core_rst_n),
        .jtag_rst_n(jtag_rst_n), .clk_restart(clk_restart), .fsm_rst(fsm_rst),
        .bpt_clear(bpt_clear), .abort_multicycle(abort_multicycle), .load_wb_kill(load_wb_kill),
        .reset_vec_go(reset_vec_go), .reset_vec_cold(reset_vec_cold),
        .sys_addr_data_bus_o(bus_o), .sys_addr_data_bus_oe(bus_oe), .big_endian(big_endian),
        .ratio_sel(ratio_sel), .core_mult_x2(core_mult_x2), .core_half_phase(core_half_phase),
        .pll_bypass(pll_bypass), .compat_proto(compat_proto), .sys_clk_phase(sys_clk_phase),
        .sys_clk_rise(sys_clk_rise));
    crs_ctl_model #(.COLD_HOLD(CMIN + 8), .RESTART_HOLD(RMIN + 4)) u_ctl (.pclk(pclk),
        .full_init_n(full_init_n), .logic_restart_n(logic_restart_n),
        .byte_order_sel(byte_order_sel), .core_ratio_sel(core_ratio_sel),
        .pll_skip_n(pll_skip_n), .compat_protocol_sel_n(compat_protocol_sel_n));
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////////
    task complete_run;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task apb(input logic wr, input logic [CRS_AW-1:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        if (pready !== 1'b1)
        begin
            check(32'h0, 32'h1, "no ready");
            complete_run();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wait_go;
        int n;
        n = 0;
        while (reset_vec_go !== 1'b1 && n < 100)
        begin
            @(posedge pclk);
            #1;
            n++;
        end
        if (n == 100)
        begin
            check(32'h0, 32'h1, "no restart");
            complete_run();
        end
    endtask
    function logic [31:0] ratio_exp(input logic [1:0] c);
        case (c)
            2'h0: return 32'h8;
            2'h1: return 32'h6;
            2'h2: return 32'h15;
            default: return 32'h4;
        endcase
    endfunction
    ////////////////////////////////////////////////////////////////////////
    task t_cold(input logic [1:0] c, input logic b, input logic p, input logic m);
        logic [31:0] st;
        logic r;
        st = {21'h0, 1'b1, CRS_RUN, 1'b1, m, p, c, b};
        u_ctl.cold_enter(c, b, p, m);
        #1;
        check({bus_oe, fsm_rst, jtag_rst_n, core_rst_n}, 4'b1100, "in reset");
        check(bus_o, 32'h0, "bus value");
        u_ctl.cold_leave();
        wait_go();
        check({reset_vec_cold, bus_oe}, 2'b10, "cold start");
        check({big_endian, ratio_sel, pll_bypass, compat_proto},
            {b, c, ~p, ~m}, "straps");
        apb(1'b0, CRS_STAT_OFF, 32'h0);
        check(rd, st, "status");
        apb(1'b0, CRS_RATIO_OFF, 32'h0);
        check(rd, p ? ratio_exp(c) : 32'h4, "ratio");
        apb(1'b0, CRS_EVT_OFF, 32'h0);
        check(rd, 32'h1, "cold event");
        apb(1'b1, CRS_EVT_OFF, 32'hF);
        u_ctl.set_straps(~c, ~b, p, ~m);
        apb(1'b0, CRS_STAT_OFF, 32'h0);
        check(rd, st, "straps moved");
        // in bypass the system clock runs at half the input rate;
        // step off the edge first so the first sample is settled
        #1;
        for (int k = 0; k < 4 && !p; k++)
        begin
            r = sys_clk_rise;
            @(posedge pclk);
            #1;
            check({sys_clk_phase, sys_clk_rise}, {~r, ~r}, "system clock phase");
        end
    endtask
    task t_warm(input int hold, input logic [31:0] ev);
        u_ctl.restart_low();
        #1;
        check({core_rst_n, abort_multicycle, load_wb_kill}, 3'b011, "abort");
        check({jtag_rst_n, bus_oe}, 2'b11, "warm keeps");
        repeat (hold) @(posedge pclk);
        u_ctl.restart_high();
        wait_go();
        check(reset_vec_cold, 1'b0, "soft start");
        apb(1'b0, CRS_EVT_OFF, 32'h0);
        check(rd, ev, "warm event");
        apb(1'b1, CRS_EVT_OFF, 32'hF);
    endtask
    task t_regs;
        apb(1'b0, CRS_CTRL_OFF, 32'h0);
        check(rd, CRS_CTRL_RST, "ctrl reset");
        apb(1'b0, 12'h010, 32'h0);
        check(err, 1'b1, "unmapped error");
        check(rd, 32'h0, "unmapped read");
        apb(1'b1, CRS_STAT_OFF, 32'h0);
        apb(1'b0, CRS_STAT_OFF, 32'h0);
        check(rd, 32'h0000_0628, "status write");
        apb(1'b1, CRS_EVT_OFF, 32'hF);
        apb(1'b0, CRS_EVT_OFF, 32'h0);
        check(rd, 32'h0, "event clear");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        errors = 0;
        compares = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_cold(2'h0, 1'b0, 1'b1, 1'b0);
        t_regs();
        t_warm(RMIN + 4, 32'h2);
        // short hold still completes, only flagged
        t_warm(RMIN / 2, 32'hA);
        apb(1'b1, CRS_CTRL_OFF, 32'h0);
        apb(1'b0, CRS_CTRL_OFF, 32'h0);
        check(rd, 32'h0, "ctrl write");
        t_warm(RMIN / 2, 32'h2);
        apb(1'b1, CRS_CTRL_OFF, 32'h1);
        for (int i = 1; i < 4; i++)
            t_cold(i[1:0], i[0], 1'b1, i[1]);
        t_cold(2'h2, 1'b1, 1'b0, 1'b1);
        complete_run();
    end
    initial
    begin
        repeat (20000) @(posedge pclk);
        check(32'h0, 32'h1, "run too long");
        complete_run();
    end
endmodule
